/* adcpd_serial_out.v */
/*
 * power-down control and per-channel DDR serial output of an
 * eight-channel 12-bit converter.
 * assumes converter words arrive on clk_sys in offset binary, already
 * clamped at the rails by the core; the bit clock comes from outside
 * the clk_sys domain and is sampled here, both edges used.
 */
`include "adcpd_regs.vh"

module adcpd_serial_out #(
    parameter LANES     = `ADCPD_LANES,
    parameter WORD_BITS = `ADCPD_WORD_BITS
) (
    // clock and reset
    input  wire                       clk_sys,
    input  wire                       reset_n,
    // power control
    input  wire                       power_down_input,
    input  wire                       sw_power_down,
    input  wire                       sw_standby,
    output reg                        reference_enable,
    output reg                        converter_enable,
    output wire [2:0]                 power_state,
    // output format control
    input  wire                       reduced_swing_select,
    input  wire                       offset_binary_select,
    output reg                        reduced_swing,
    // drive strength register port
    input  wire [7:0]                 cfg_addr,
    input  wire                       cfg_write,
    input  wire [`ADCPD_REG_WIDTH-1:0] cfg_wdata,
    output reg  [`ADCPD_REG_WIDTH-1:0] cfg_rdata,
    output reg  [`ADCPD_REG_WIDTH-1:0] drive_boost,
    // converter samples, one word per channel
    input  wire                       sample_valid,
    output wire                       sample_ready,
    input  wire [LANES*WORD_BITS-1:0] sample_data,
    // link bit clock from outside
    input  wire                       lane_clk,
    // serial outputs
    output wire [LANES-1:0]           lane_data,
    output reg                        data_clk_out,
    output reg                        frame_clk_out,
    output reg                        output_enable
);

    // one-hot power states
    localparam [2:0] ST_RUN     = 3'h1;
    localparam [2:0] ST_STANDBY = 3'h2;
    localparam [2:0] ST_DOWN    = 3'h4;

    reg  [2:0]                 state;        // current power state
    reg  [2:0]                 next_state;   // state for next edge
    reg                        pd_s1;        // pin sync, first stage
    reg                        pd_s2;        // pin sync, second stage
    reg                        lclk_s1;      // bit clock sync, first stage
    reg                        lclk_s2;      // bit clock sync, second stage
    reg                        lclk_d;       // previous synced bit clock
    reg  [`ADCPD_CNT_WIDTH-1:0] bit_cnt;     // bit position in word
    wire                       lclk_edge;    // either edge of bit clock
    wire                       running;      // conversion active
    wire                       word_start;   // first bit of a word
    wire                       buf_valid;    // buffer has a word
    wire                       buf_take;     // serializer takes word
    wire [LANES*WORD_BITS-1:0] buf_data;     // word at buffer head

    assign power_state = state;
    assign running     = (state == ST_RUN);
    assign lclk_edge   = lclk_s2 ^ lclk_d;
    assign word_start  = (bit_cnt == {`ADCPD_CNT_WIDTH{1'b0}});
    assign buf_take    = running && lclk_edge && word_start;

    // two-flop synchronisers for pin and bit clock
    // lclk_d is a third stage, read only by the edge detector
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pd_s1   <= 1'b0;
            pd_s2   <= 1'b0;
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_d  <= 1'b0;
        end else begin
            pd_s1   <= power_down_input;
            pd_s2   <= pd_s1;
            lclk_s1 <= lane_clk;
            lclk_s2 <= lclk_s1;
            lclk_d  <= lclk_s2;
        end
    end

    // power state selection
    // down wins over standby; the pin is only seen once synced,
    // so a software request acts two edges sooner than the pin
    always @* begin
        next_state = state;
        case (state)
            ST_RUN, ST_STANDBY, ST_DOWN: begin
                if (pd_s2 || sw_power_down) begin
                    next_state = ST_DOWN;
                end else if (sw_standby) begin
                    next_state = ST_STANDBY;
                end else begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_DOWN;
            end
        endcase
    end

    // power state register and analog enables
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state            <= ST_RUN;
            reference_enable <= 1'b1;
            converter_enable <= 1'b1;
            output_enable    <= 1'b1;
        end else begin
            state            <= next_state;
            // standby keeps the reference alive for fast wake-up
            reference_enable <= (next_state != ST_DOWN);
            converter_enable <= (next_state == ST_RUN);
            // drivers released whenever not converting
            output_enable    <= (next_state == ST_RUN);
        end
    end

    // swing select and drive strength register
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reduced_swing <= 1'b0;
            drive_boost   <= `ADCPD_DRIVE_RESET;
            cfg_rdata     <= {`ADCPD_REG_WIDTH{1'b0}};
        end else begin
            // standard swing until software asks otherwise
            reduced_swing <= reduced_swing_select;
            if (cfg_write && (cfg_addr == `ADCPD_DRIVE_OFFSET)) begin
                drive_boost <= cfg_wdata;
            end
            // unmapped offsets read as zero
            if (cfg_addr == `ADCPD_DRIVE_OFFSET) begin
                cfg_rdata <= drive_boost;
            end else begin
                cfg_rdata <= {`ADCPD_REG_WIDTH{1'b0}};
            end
        end
    end

    // holds up to two sample sets while the serializer is busy
    // the serializer pops only at a word boundary
    adcpd_buffer #(
        .WIDTH(LANES*WORD_BITS)
    ) u_buffer (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .in_valid (sample_valid),
        .in_ready (sample_ready),
        .in_data  (sample_data),
        .out_valid(buf_valid),
        .out_ready(buf_take),
        .out_data (buf_data)
    );

    // bit counter, data clock and frame clock
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt       <= {`ADCPD_CNT_WIDTH{1'b0}};
            data_clk_out  <= 1'b0;
            frame_clk_out <= 1'b0;
        end else if (!running) begin
            // idle framing while not converting
            bit_cnt       <= {`ADCPD_CNT_WIDTH{1'b0}};
            data_clk_out  <= 1'b0;
            frame_clk_out <= 1'b0;
        end else if (lclk_edge) begin
            // one bit per bit clock edge, DDR
            if (bit_cnt == `ADCPD_LAST_BIT) begin
                bit_cnt <= {`ADCPD_CNT_WIDTH{1'b0}};
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            // toggle rather than copy the synced bit clock, so the
            // first bit after a wake-up also carries a clock edge
            data_clk_out  <= ~data_clk_out;
            // frame high for first half of each word
            frame_clk_out <= (bit_cnt < `ADCPD_FRAME_HIGH_BITS);
        end
    end

    // per-lane coding and shift register
    genvar i;
    generate
        for (i = 0; i < LANES; i = i + 1) begin : g_lane
            wire [WORD_BITS-1:0] raw;    // core code, offset binary
            wire [WORD_BITS-1:0] coded;  // code in selected format
            reg  [WORD_BITS-1:0] shift;  // bits still to send

            // an empty buffer sends the zero-input code
            assign raw = buf_valid ? buf_data[i*WORD_BITS +: WORD_BITS]
                                   : `ADCPD_CODE_MID;
            // offset binary passes through; two's complement flips msb
            assign coded = offset_binary_select ? raw
                         : {~raw[WORD_BITS-1], raw[WORD_BITS-2:0]};
            assign lane_data[i] = shift[WORD_BITS-1];

            // load at word start, shift msb first on each edge
            always @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    shift <= {WORD_BITS{1'b0}};
                end else if (!running) begin
                    shift <= {WORD_BITS{1'b0}};
                end else if (lclk_edge) begin
                    if (word_start) begin
                        shift <= coded;
                    end else begin
                        shift <= {shift[WORD_BITS-2:0], 1'b0};
                    end
                end
            end
        end
    endgenerate

endmodule

/* adcpd_regs.vh */
/*
 * constants for the converter power-down and serial output block:
 * register offsets, reset values, word layout and lane counts.
 * assumes it is included by bare name from the block's design files.
 */
`ifndef ADCPD_REGS_VH
`define ADCPD_REGS_VH

// register map
`define ADCPD_DRIVE_OFFSET      8'h15
`define ADCPD_DRIVE_RESET       8'h00
`define ADCPD_REG_WIDTH         8

// sample word and lane layout
`define ADCPD_WORD_BITS         12
`define ADCPD_LANES             8
`define ADCPD_FRAME_HIGH_BITS   4'h6
`define ADCPD_LAST_BIT          4'hB
`define ADCPD_CNT_WIDTH         4

// output coding anchors, offset binary view
`define ADCPD_CODE_MID          12'h800

`endif

/* adcpd_buffer.v */
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes both sides run on clk_sys; a stall on the drain side
 * fills it and then drops in_ready toward the source.
 */
module adcpd_buffer #(
    parameter WIDTH = 96
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             reset_n,
    // filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] store [0:1];  // the two entries
    reg             wr_ptr;       // next entry to fill
    reg             rd_ptr;       // next entry to drain
    reg [1:0]       fill;         // words held, 0..2

    wire push = in_valid && in_ready;   // word accepted
    wire pop  = out_valid && out_ready; // word handed on

    // honest full and empty flags
    assign in_ready  = (fill != 2'h2);
    assign out_valid = (fill != 2'h0);
    assign out_data  = store[rd_ptr];

    // entry storage, no reset needed on data
    always @(posedge clk_sys) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fill   <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            // level moves only when one side acts alone
            if (push && !pop) begin
                fill <= fill + 2'h1;
            end else if (pop && !push) begin
                fill <= fill - 2'h1;
            end
        end
    end

endmodule

/* adcpd_serial_out_asserts.sv */
/* checker for power control, drive register and word framing of adcpd_serial_out.
   assumes it is bound onto that module and that everything runs on clk_sys. */
module adcpd_chk (
    // clock and reset
    input wire       clk_sys,
    input wire       reset_n,
    // power control
    input wire       power_down_input,
    input wire       sw_power_down,
    input wire       sw_standby,
    input wire       reference_enable,
    input wire       converter_enable,
    input wire [2:0] power_state,
    input wire       output_enable,
    // register port and framing
    input wire [7:0] cfg_addr,
    input wire       cfg_write,
    input wire [7:0] cfg_wdata,
    input wire [7:0] cfg_rdata,
    input wire [7:0] drive_boost,
    input wire       frame_clk_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // requests held long enough to pass the pin synchronizer
    sequence s_pin_held; power_down_input [*3]; endsequence
    sequence s_stby_held; (sw_standby && !sw_power_down && !power_down_input) [*3]; endsequence
    sequence s_run_held; (!sw_standby && !sw_power_down && !power_down_input) [*3]; endsequence
    property p_pin_down; s_pin_held |=> power_state == 3'b100; endproperty
    a_pin_down: assert property (p_pin_down) else $error("pin did not power down");
    property p_sw_down; sw_power_down |=> power_state == 3'b100; endproperty
    a_sw_down: assert property (p_sw_down) else $error("software did not power down");
    property p_down_off; power_state == 3'b100 |-> !output_enable && !reference_enable && !converter_enable; endproperty
    a_down_off: assert property (p_down_off) else $error("drivers active while down");
    property p_standby; s_stby_held |=> power_state == 3'b010 && reference_enable && !output_enable; endproperty
    a_standby: assert property (p_standby) else $error("standby state wrong");
    property p_run; s_run_held |=> power_state == 3'b001 && output_enable && converter_enable; endproperty
    a_run: assert property (p_run) else $error("no return to conversion");
    property p_boost_wr; cfg_write && cfg_addr == 8'h15 |=> drive_boost == $past(cfg_wdata); endproperty
    a_boost_wr: assert property (p_boost_wr) else $error("drive write lost");
    property p_read; 1 |=> cfg_rdata == (($past(cfg_addr) == 8'h15) ? $past(drive_boost) : 8'h00); endproperty
    a_read: assert property (p_read) else $error("read data wrong");
    // six bit halves of four clk_sys cycles each at the bench link rate
    property p_frame; disable iff (!reset_n || !output_enable) $rose(frame_clk_out) |-> ##[23:25] $fell(frame_clk_out); endproperty
    a_frame: assert property (p_frame) else $error("frame high time wrong");
endmodule
bind adcpd_serial_out adcpd_chk u_chk (.clk_sys, .reset_n, .power_down_input, .sw_power_down, .sw_standby,
    .reference_enable, .converter_enable, .power_state, .output_enable, .cfg_addr, .cfg_write, .cfg_wdata,
    .cfg_rdata, .drive_boost, .frame_clk_out);

/* adcpd_rx_model.sv */
/* receiver model: deserializes all eight lanes from the forwarded clocks.
   assumes data_clk_out and lane_data change on the same clk_sys edge. */
module adcpd_rx_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // forwarded link
    input  wire logic [7:0]  lane_data,
    input  wire logic        data_clk_out,
    input  wire logic        frame_clk_out,
    input  wire logic        output_enable,
    // recovered sample set
    output logic      [95:0] rx_word,
    output logic             rx_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] lane_seen;  // wire level, released lanes show the inverse
    logic [7:0] lane_last;  // last driven level
    logic       dclk_last;  // data clock at previous edge
    logic       frame_last; // frame level at previous bit
    logic [3:0] bit_cnt;    // bits of current word, 12 = unsynced
    assign lane_seen = output_enable ? lane_data : ~lane_last;
    // one bit per data clock edge, word start at frame rise
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            {dclk_last, frame_last, rx_valid, lane_last} <= '0;
            bit_cnt <= 4'hC;
        end else begin
            dclk_last <= data_clk_out;
            rx_valid <= 1'b0;
            if (output_enable) lane_last <= lane_data;
            if (!output_enable) bit_cnt <= 4'hC; // released: resync
            else if (data_clk_out != dclk_last) begin
                frame_last <= frame_clk_out;
                for (int i = 0; i < 8; i++) rx_word[12*i +: 12] <= {rx_word[12*i +: 11], lane_seen[i]};
                rx_valid <= (bit_cnt == 4'hB);
                if (frame_clk_out && !frame_last) bit_cnt <= 4'h1;
                else if (bit_cnt != 4'hC) bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end
endmodule

/* adcpd_serial_out_test.sv */
/* self-checking bench for adcpd_serial_out with the receiver model.
   assumes the 160 ns link clock and default parameters. */
module adcpd_serial_out_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 0, reset_n = 0, lane_clk = 0;       // clocks and reset
    logic        power_down_input = 0, sw_power_down = 0, sw_standby = 0;
    logic        reduced_swing_select = 0, offset_binary_select = 0, cfg_write = 0, sample_valid = 0;
    logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, wd;     // register port
    logic [95:0] sample_data = '0;                               // sample set
    wire         reference_enable, converter_enable, reduced_swing, sample_ready;
    wire         data_clk_out, frame_clk_out, output_enable, rx_valid;
    wire  [2:0]  power_state;
    wire  [7:0]  cfg_rdata, drive_boost, lane_data;
    wire  [95:0] rx_word;
    logic [95:0] exp_q[$];                                       // expected sets
    integer      seed = 32'hF2AC, num_errors = 0, check_count = 0, cycles = 0;
    adcpd_serial_out dut (.clk_sys, .reset_n, .power_down_input, .sw_power_down, .sw_standby,
        .reference_enable, .converter_enable, .power_state, .reduced_swing_select, .offset_binary_select,
        .reduced_swing, .cfg_addr, .cfg_write, .cfg_wdata, .cfg_rdata, .drive_boost, .sample_valid,
        .sample_ready, .sample_data, .lane_clk, .lane_data, .data_clk_out, .frame_clk_out, .output_enable);
    adcpd_rx_model rx (.clk_sys, .reset_n, .lane_data, .data_clk_out, .frame_clk_out, .output_enable,
        .rx_word, .rx_valid);
    always #10 clk_sys = ~clk_sys;
    // link clock, phase unrelated to clk_sys
    initial begin
        #7;
        forever #80 lane_clk = ~lane_clk;
    end
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t mismatch %h %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // one register cycle, write strobe one clock wide
    task cfg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        cfg_addr <= a;
        cfg_write <= 1'b1;
        cfg_wdata <= v;
        @(posedge clk_sys);
        cfg_write <= 1'b0;
        settle(2);
    endtask
    // hold the set until taken, then note its coded form
    task push(input logic [95:0] d);
        sample_data <= d;
        sample_valid <= 1'b1;
        @(negedge clk_sys);
        while (sample_ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        exp_q.push_back(d ^ {8{~offset_binary_select, 11'h000}});
    endtask
    // random sets with the two rail codes and the midscale code, then drain
    task stream(input logic ob);
        logic [95:0] d;
        @(posedge clk_sys);
        offset_binary_select <= ob;
        repeat (100) @(posedge clk_sys);
        for (int k = 0; k < 9; k++) begin
            d = {$random(seed), $random(seed), $random(seed)};
            if (k == 1) d = 96'h0;
            if (k == 2) d = {8{12'h800}};
            if (k == 3) d = {8{12'hFFF}};
            push(d);
        end
        sample_valid <= 1'b0;
        while (exp_q.size() > 0) @(posedge clk_sys);
    endtask
    // compare each recovered set, idle sets before the first are skipped
    always @(negedge clk_sys) begin
        if (rx_valid === 1'b1 && exp_q.size() > 0)
            if (rx_word === exp_q[0] || rx_word !== {8{offset_binary_select, 11'h000}})
                check(rx_word, exp_q.pop_front());
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        settle(1);
        check(drive_boost, 8'h00);
        check(reduced_swing, 1'b0);
        check(sample_ready, 1'b1);
        wd = 8'($random(seed));
        cfg(8'h15, wd);
        check(drive_boost, wd);
        check(cfg_rdata, wd);
        cfg(8'h16, ~wd);
        check(drive_boost, wd);
        check(cfg_rdata, 8'h00);
        @(posedge clk_sys);
        reduced_swing_select <= 1'b1;
        sw_standby <= 1'b1;
        settle(2);
        check(reduced_swing, 1'b1);
        check({power_state, reference_enable, output_enable}, 5'b01010);
        @(posedge clk_sys);
        sw_power_down <= 1'b1;
        settle(2);
        check(power_state, 3'b100);
        @(posedge clk_sys);
        {sw_power_down, sw_standby, power_down_input} <= 3'b001;
        settle(4);
        check({power_state, output_enable, converter_enable}, 5'b10000);
        @(posedge clk_sys);
        power_down_input <= 1'b0;
        settle(4);
        check({power_state, output_enable}, 4'b0011);
        repeat (200) @(posedge clk_sys);
        stream(1'b0);
        stream(1'b1);
        tally_and_finish;
    end
endmodule
